// [inc/cdi_consts.svh]
// offsets, field positions, reset values and timing counts of the instruction unit
`ifndef CDI_CONSTS_SVH
`define CDI_CONSTS_SVH

`define CDI_OFF_INSTR 8'h00
`define CDI_OFF_DATA 8'h04
`define CDI_OFF_STATUS 8'h08

`define CDI_SPACE_CODE 8'h20
`define CDI_HOME_ADDR 7'h00
`define CDI_CHAR_L1_END 7'h27
`define CDI_CHAR_L2_START 7'h40
`define CDI_CHAR_L2_END 7'h67
`define CDI_GLYPH_END 6'h3f
`define CDI_SHIFT_LAST 6'h27
`define CDI_LUMA_RST 2'h0

`define CDI_CLK_KHZ 50000
`define CDI_BLINK_HALF_MS 500
`define CDI_BLINK_HALF_CYC (`CDI_BLINK_HALF_MS * `CDI_CLK_KHZ)

// status word bit positions
`define CDI_ST_DIR 0
`define CDI_ST_AUTO 1
`define CDI_ST_DISP 2
`define CDI_ST_CUR 3
`define CDI_ST_BLINK 4
`define CDI_ST_BUSW 5
`define CDI_ST_LINES 6
`define CDI_ST_LUMA 7
`define CDI_ST_GLYPH 9
`define CDI_ST_PHASE 10
`define CDI_ST_SHIFT 16

`endif

// [inc/cdi_pkg.sv]
// types shared by the instruction unit
package cdi_pkg;

    typedef enum logic [10:0] {
        CDI_OP_NONE   = 11'b000_0000_0001,
        CDI_OP_CLEAR  = 11'b000_0000_0010,
        CDI_OP_HOME   = 11'b000_0000_0100,
        CDI_OP_ENTRY  = 11'b000_0000_1000,
        CDI_OP_DISP   = 11'b000_0001_0000,
        CDI_OP_SHIFT  = 11'b000_0010_0000,
        CDI_OP_FUNC   = 11'b000_0100_0000,
        CDI_OP_GLYPH  = 11'b000_1000_0000,
        CDI_OP_CHAR   = 11'b001_0000_0000,
        CDI_OP_DATAWR = 11'b010_0000_0000,
        CDI_OP_DATARD = 11'b100_0000_0000
    } cdi_op_type;

endpackage

// [src/cdi_instruction_unit.sv]
// instruction interpreter of a two-line character display, reached over ahb-lite
//
// Overview of operation
// - home: pointer to 00H, shift cleared
// - direction 0: decrement; auto-shift right on writes
// - direction 1: increment; auto-shift left on writes
// - auto-shift only after character memory writes
// - display control sets display, cursor, blink
// - blink alternates cursor character at 1Hz
// - shift instruction steps pointer, optionally shifts display
// - shift instruction returns pointer to character memory
// - bus-width bit selects 4 or 8 bit
// - line-count bit selects one or two lines
// - two-bit luminance code sets brightness
// - glyph address loads six bits, targets glyphs
// - character address loads seven bits, targets characters
// - pointer read returns pointer, busy always 0
// - data write stores byte, steps pointer, shifts
// - data read returns byte, steps pointer
// - reset fills spaces, pointer 00H, unshifted
// - reset defaults: increment, display off, 8-bit, two lines
// - setting instructions touch only their bits
// - character pointer wraps between the two lines
// - glyph pointer wraps within 00H..3FH
// - clear fills spaces, home, sets increment
`timescale 1ns/1ns
`default_nettype none
`include "cdi_consts.svh"

module cdi_instruction_unit
    import cdi_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYC = `CDI_BLINK_HALF_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic display_on_out,
    output logic cursor_on_out,
    output logic blink_show_full_out,
    output logic bus_width_bit_out,
    output logic two_lines_out,
    output logic [1:0] luminance_out,
    output logic [5:0] shift_offset_out,
    output logic [6:0] cursor_addr_out
);

    // =====================================================================
    // state
    // =====================================================================
    logic [7:0] char_code_memory [0:127];
    logic [7:0] glyph_pattern_memory [0:63];
    logic [6:0] addr_pointer_r;
    logic glyph_target_r;
    logic dir_inc_r;
    logic auto_shift_r;
    logic disp_en_r;
    logic cur_en_r;
    logic blink_en_r;
    logic bus_width_bit_r;
    logic two_lines_r;
    logic luminance_high_bit_r;
    logic luminance_low_bit_r;
    logic [5:0] shift_r;
    logic [24:0] blink_cnt_r;
    logic blink_phase_r;
    logic pend_r;
    logic pend_wr_r;
    logic [7:0] pend_addr_r;
    logic hreadyout_r;
    logic [31:0] hrdata_r;

    // =====================================================================
    // bus slave: one wait state for every transfer
    // =====================================================================
    logic accept;
    // taken only once the previous data phase has ended
    assign accept = hsel_in && htrans_in[1] && hready_in;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_r <= 1'b0;
            pend_wr_r <= 1'b0;
            pend_addr_r <= 8'h00;
            hreadyout_r <= 1'b1;
        end else begin
            pend_r <= accept;
            hreadyout_r <= !accept;
            if (accept) begin
                pend_wr_r <= hwrite_in;
                pend_addr_r <= haddr_in[7:0];
            end
        end
    end

    // =====================================================================
    // decode
    // =====================================================================
    cdi_op_type op;
    logic [7:0] cmd;
    // instruction byte stands on the bus in the data phase
    assign cmd = hwdata_in[7:0];

    always_comb begin
        op = CDI_OP_NONE;
        if (pend_r && pend_addr_r == `CDI_OFF_DATA) begin
            op = pend_wr_r ? CDI_OP_DATAWR : CDI_OP_DATARD;
        end else if (pend_r && pend_wr_r && pend_addr_r == `CDI_OFF_INSTR) begin
            casez (cmd)
                8'b1???_????: op = CDI_OP_CHAR;
                8'b01??_????: op = CDI_OP_GLYPH;
                8'b001?_????: op = CDI_OP_FUNC;
                8'b0001_????: op = CDI_OP_SHIFT;
                8'b0000_1???: op = CDI_OP_DISP;
                8'b0000_01??: op = CDI_OP_ENTRY;
                8'b0000_001?: op = CDI_OP_HOME;
                8'b0000_0001: op = CDI_OP_CLEAR;
                default: op = CDI_OP_NONE;
            endcase
        end
    end

    // =====================================================================
    // pointer stepping
    // =====================================================================
    function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic glyph, input logic inc);
        logic [6:0] r;
        r = inc ? 7'(p + 7'd1) : 7'(p - 7'd1);
        if (glyph) begin
            r = {1'b0, r[5:0]};
        end else if (inc) begin
            if (p == `CDI_CHAR_L1_END) begin
                r = `CDI_CHAR_L2_START;
            end else if (p == `CDI_CHAR_L2_END) begin
                r = `CDI_HOME_ADDR;
            end
        end else begin
            if (p == `CDI_CHAR_L2_START) begin
                r = `CDI_CHAR_L1_END;
            end else if (p == `CDI_HOME_ADDR) begin
                r = `CDI_CHAR_L2_END;
            end
        end
        return r;
    endfunction

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_pointer_r <= `CDI_HOME_ADDR;
            glyph_target_r <= 1'b0;
        end else begin
            unique case (op)
                CDI_OP_CLEAR, CDI_OP_HOME: begin
                    addr_pointer_r <= `CDI_HOME_ADDR;
                    glyph_target_r <= 1'b0;
                end
                // step into character memory
                // glyph pointer reused as a character address
                CDI_OP_SHIFT: begin
                    addr_pointer_r <= step_ptr(glyph_target_r ? {1'b0, addr_pointer_r[5:0]} : addr_pointer_r,
                                               1'b0, cmd[2]);
                    glyph_target_r <= 1'b0;
                end
                CDI_OP_GLYPH: begin
                    addr_pointer_r <= {1'b0, cmd[5:0]};
                    glyph_target_r <= 1'b1;
                end
                CDI_OP_CHAR: begin
                    addr_pointer_r <= cmd[6:0];
                    glyph_target_r <= 1'b0;
                end
                CDI_OP_DATAWR, CDI_OP_DATARD: begin
                    addr_pointer_r <= step_ptr(addr_pointer_r, glyph_target_r, dir_inc_r);
                end
                default: begin
                end
            endcase
        end
    end

    // =====================================================================
    // memories
    // =====================================================================
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // every location is a flop, so it fills at once
            // spaces at reset
            for (int i = 0; i < 128; i++) begin
                char_code_memory[i] <= `CDI_SPACE_CODE;
            end
        end else if (op == CDI_OP_CLEAR) begin
            for (int i = 0; i < 128; i++) begin
                char_code_memory[i] <= `CDI_SPACE_CODE;
            end
        end else if (op == CDI_OP_DATAWR && !glyph_target_r) begin
            char_code_memory[addr_pointer_r] <= hwdata_in[7:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (op == CDI_OP_DATAWR && glyph_target_r) begin
            glyph_pattern_memory[addr_pointer_r[5:0]] <= hwdata_in[7:0];
        end
    end

    // =====================================================================
    // settings
    // =====================================================================
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dir_inc_r <= 1'b1;
            auto_shift_r <= 1'b0;
            disp_en_r <= 1'b0;
            cur_en_r <= 1'b0;
            blink_en_r <= 1'b0;
            bus_width_bit_r <= 1'b1;
            two_lines_r <= 1'b1;
            {luminance_high_bit_r, luminance_low_bit_r} <= `CDI_LUMA_RST;
        end else begin
            // each setting instruction touches its own bits; clear also sets increment
            unique case (op)
                CDI_OP_CLEAR: begin
                    dir_inc_r <= 1'b1;
                end
                CDI_OP_ENTRY: begin
                    dir_inc_r <= cmd[1];
                    auto_shift_r <= cmd[0];
                end
                CDI_OP_DISP: begin
                    disp_en_r <= cmd[2];
                    cur_en_r <= cmd[1];
                    blink_en_r <= cmd[0];
                end
                CDI_OP_FUNC: begin
                    bus_width_bit_r <= cmd[4];
                    two_lines_r <= cmd[3];
                    luminance_high_bit_r <= cmd[1];
                    luminance_low_bit_r <= cmd[0];
                end
                default: begin
                end
            endcase
        end
    end

    // =====================================================================
    // display shift: left shift advances the first visible column
    // =====================================================================
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_r <= 6'd0;
        end else if (op == CDI_OP_CLEAR || op == CDI_OP_HOME) begin
            shift_r <= 6'd0;
        end else if ((op == CDI_OP_SHIFT && cmd[3]) ||
                     (op == CDI_OP_DATAWR && !glyph_target_r && auto_shift_r)) begin
            if ((op == CDI_OP_SHIFT) ? !cmd[2] : dir_inc_r) begin
                shift_r <= (shift_r == `CDI_SHIFT_LAST) ? 6'd0 : 6'(shift_r + 6'd1);
            end else begin
                shift_r <= (shift_r == 6'd0) ? `CDI_SHIFT_LAST : 6'(shift_r - 6'd1);
            end
        end
    end

    // =====================================================================
    // blink divider
    // =====================================================================
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            blink_cnt_r <= 25'd0;
            blink_phase_r <= 1'b0;
        end else if (blink_cnt_r == 25'(BLINK_HALF_CYC - 1)) begin
            blink_cnt_r <= 25'd0;
            blink_phase_r <= !blink_phase_r;
        end else begin
            blink_cnt_r <= 25'(blink_cnt_r + 25'd1);
        end
    end

    // =====================================================================
    // read data and outputs
    // =====================================================================
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`CDI_ST_DIR] = dir_inc_r;
        status_word[`CDI_ST_AUTO] = auto_shift_r;
        status_word[`CDI_ST_DISP] = disp_en_r;
        status_word[`CDI_ST_CUR] = cur_en_r;
        status_word[`CDI_ST_BLINK] = blink_en_r;
        status_word[`CDI_ST_BUSW] = bus_width_bit_r;
        status_word[`CDI_ST_LINES] = two_lines_r;
        status_word[`CDI_ST_LUMA +: 2] = {luminance_high_bit_r, luminance_low_bit_r};
        status_word[`CDI_ST_GLYPH] = glyph_target_r;
        status_word[`CDI_ST_PHASE] = blink_phase_r;
        status_word[`CDI_ST_SHIFT +: 6] = shift_r;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hrdata_r <= 32'h0000_0000;
        end else if (pend_r && !pend_wr_r) begin
            if (op == CDI_OP_DATARD) begin
                hrdata_r <= {24'h00_0000, glyph_target_r ? glyph_pattern_memory[addr_pointer_r[5:0]]
                                                          : char_code_memory[addr_pointer_r]};
            end else if (pend_addr_r == `CDI_OFF_INSTR) begin
                hrdata_r <= {24'h00_0000, 1'b0, addr_pointer_r};
            end else if (pend_addr_r == `CDI_OFF_STATUS) begin
                hrdata_r <= status_word;
            end else begin
                hrdata_r <= 32'h0000_0000;
            end
        end
    end

    logic blink_r;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            blink_r <= 1'b0;
        end else begin
            // registered, so it lags the phase by one cycle
            // full-on half of blink
            blink_r <= blink_en_r && blink_phase_r;
        end
    end

    assign hrdata_out = hrdata_r;
    assign hreadyout_out = hreadyout_r;
    assign hresp_out = 1'b0;
    assign display_on_out = disp_en_r;
    assign cursor_on_out = cur_en_r;
    assign blink_show_full_out = blink_r;
    assign bus_width_bit_out = bus_width_bit_r;
    assign two_lines_out = two_lines_r;
    assign luminance_out = {luminance_high_bit_r, luminance_low_bit_r};
    assign shift_offset_out = shift_r;
    assign cursor_addr_out = addr_pointer_r;

endmodule // cdi_instruction_unit
`default_nettype wire

// [tb/cdi_instruction_unit_sva.sv]
// assertions on the instruction unit ports
`timescale 1ns/1ns
`default_nettype none
module cdi_instruction_unit_sva #(
    parameter int unsigned BLINK_HALF_CYC = 8
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic display_on_out,
    input wire logic cursor_on_out,
    input wire logic blink_show_full_out,
    input wire logic bus_width_bit_out,
    input wire logic two_lines_out,
    input wire logic [1:0] luminance_out,
    input wire logic [5:0] shift_offset_out,
    input wire logic [6:0] cursor_addr_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    int unsigned hi_cnt;
    // ====================
    // length of one high blink phase
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= blink_show_full_out ? hi_cnt + 1 : 0;
        end
    end
    // ====================
    // assertions
    resp_okay_a: assert property (hresp_out == 1'b0)
        else $error("response not okay");
    one_wait_a: assert property (hsel_in && htrans_in[1] && hready_in |=> !hreadyout_out ##1 hreadyout_out)
        else $error("wait state wrong");
    ptr_timed_a: assert property ($changed(cursor_addr_out) |-> $past(hreadyout_out) == 1'b0)
        else $error("pointer moved outside a transfer");
    set_timed_a: assert property ($changed({display_on_out, cursor_on_out, bus_width_bit_out, two_lines_out,
        luminance_out, shift_offset_out}) |-> $past(hreadyout_out) == 1'b0)
        else $error("setting moved outside a transfer");
    blink_half_a: assert property (hi_cnt <= BLINK_HALF_CYC)
        else $error("blink high phase too long");
    shift_range_a: assert property (shift_offset_out < 6'd40)
        else $error("shift out of range");
    shift_step_a: assert property ($changed(shift_offset_out) |-> shift_offset_out == 6'd0 ||
        shift_offset_out == 6'd39 || shift_offset_out == $past(shift_offset_out) + 6'd1 ||
        shift_offset_out + 6'd1 == $past(shift_offset_out))
        else $error("shift moved by more than one");
    rdata_hold_a: assert property (hreadyout_out && $past(hreadyout_out) |-> $stable(hrdata_out))
        else $error("read data changed while idle");
endmodule // cdi_instruction_unit_sva
`default_nettype wire

// [tb/cdi_host_model.sv]
// ahb-lite host that drives the instruction unit
`timescale 1ns/1ns
`default_nettype none
module cdi_host_model (
    input wire logic mclk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    initial begin
        hsel_out = 1'b0;
        haddr_out = 32'h0000_0000;
        htrans_out = 2'b00;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hwdata_out = 32'h0000_0000;
    end
    // one transfer at a time: address phase, then data phase with the bus idle
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge mclk_in);
        hsel_out <= 1'b1;
        htrans_out <= 2'b10;
        haddr_out <= 32'(addr);
        hwrite_out <= wr;
        do @(posedge mclk_in); while (hready_in !== 1'b1);
        hsel_out <= 1'b0;
        htrans_out <= 2'b00;
        haddr_out <= ~haddr_out;
        hwrite_out <= ~wr;
        hwdata_out <= wr ? wdata : ~hwdata_out;
        do @(posedge mclk_in); while (hready_in !== 1'b1);
        rdata = hrdata_in;
        hwdata_out <= ~hwdata_out;
    endtask
endmodule // cdi_host_model
`default_nettype wire

// [tb/tb_cdi_instruction_unit.sv]
// self-checking bench for the instruction unit
`timescale 1ns/1ns
`default_nettype none
module tb_cdi_instruction_unit;
    localparam int unsigned HALF = 8;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel, hwrite, hrdy, hresp, disp, cur, blink, busw, lines;
    logic [1:0] htrans, luma;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [5:0] shift;
    logic [6:0] ptr;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int sh = 0;
    logic [7:0] st [5] = '{8'h27, 8'h67, 8'h40, 8'h00, 8'h05};
    logic [7:0] nx [5] = '{8'h40, 8'h00, 8'h27, 8'h67, 8'h06};
    logic [4:0] dr = 5'b10011;
    logic [7:0] sc [4] = '{8'h14, 8'h1c, 8'h18, 8'h13};
    always #10 mclk = ~mclk;
    cdi_host_model u_host (.mclk_in(mclk), .hready_in(hrdy), .hrdata_in(hrdata), .hsel_out(hsel),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));
    cdi_instruction_unit #(.BLINK_HALF_CYC(HALF)) DUT (.mclk_in(mclk), .rst_n_in(rst_n), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
        .display_on_out(disp), .cursor_on_out(cur), .blink_show_full_out(blink), .bus_width_bit_out(busw),
        .two_lines_out(lines), .luminance_out(luma), .shift_offset_out(shift), .cursor_addr_out(ptr));
    // ====================
    // helpers
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        u_host.xfer(1'b1, a, 32'(d), r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        u_host.xfer(1'b0, a, 32'h0000_0000, r);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        rd(a, r);
        chk(r, exp);
    endtask
    task automatic blink_cnt(output int n);
        n = 0;
        repeat (32) begin
            @(posedge mclk);
            n += (blink === 1'b0) ? 0 : 1;
        end
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            num_errors++;
            stop_test();
        end
    end
    // ====================
    // main sequence
    initial begin
        logic [31:0] r;
        logic [3:0] k;
        int n;
        int p;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'h08, r);
        chk(r & 32'hffff_fbff, 32'h0000_0061);
        rdchk(8'h00, 32'h0000_0000);
        rdchk(8'h04, 32'h0000_0020);
        chk(32'(ptr), 32'h0000_0001);
        rdchk(8'h0c, 32'h0000_0000);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            wr(8'h00, {3'b001, k[3], k[2], k[0], k[1], k[0]});
            chk(32'({busw, lines, luma}), 32'(k));
            chk(32'(ptr), 32'h0000_0001);
        end
        for (int i = 0; i < 8; i++) begin
            k = 4'(i);
            wr(8'h00, {5'b00001, k[2:0]});
            chk(32'({disp, cur}), 32'(k[2:1]));
        end
        blink_cnt(n);
        chk(32'(n), 32'h0000_0010);
        wr(8'h00, 8'h0c);
        blink_cnt(n);
        chk(32'(n), 32'h0000_0000);
        $display("test settings done");
        for (int i = 0; i < 5; i++) begin
            wr(8'h00, {6'b000001, dr[i], 1'b1});
            wr(8'h00, {1'b1, st[i][6:0]});
            wr(8'h04, st[i] ^ 8'h5a);
            sh += dr[i] ? 1 : -1;
            chk(32'(ptr), 32'(nx[i]));
            chk(32'(shift), 32'(sh));
            wr(8'h00, {6'b000001, dr[i], 1'b0});
            wr(8'h00, {1'b1, st[i][6:0]});
            rdchk(8'h04, 32'(st[i] ^ 8'h5a));
            chk(32'({ptr, shift}), 32'({nx[i][6:0], 6'(sh)}));
        end
        $display("test char memory done");
        wr(8'h00, 8'h07);
        wr(8'h00, 8'h7f);
        wr(8'h04, 8'ha5);
        chk(32'({ptr, shift}), 32'({7'h00, 6'(sh)}));
        wr(8'h00, 8'h05);
        wr(8'h00, 8'h40);
        wr(8'h04, 8'h3c);
        chk(32'(ptr), 32'h0000_003f);
        wr(8'h00, 8'h06);
        wr(8'h00, 8'h7f);
        rdchk(8'h04, 32'h0000_00a5);
        rdchk(8'h04, 32'h0000_003c);
        rd(8'h08, r);
        chk(32'(r[9]), 32'h0000_0001);
        p = 1;
        for (int j = 0; j < 4; j++) begin
            wr(8'h00, sc[j]);
            p += sc[j][2] ? 1 : -1;
            sh += sc[j][3] ? (sc[j][2] ? -1 : 1) : 0;
            chk(32'({ptr, shift}), 32'({7'(p), 6'(sh)}));
        end
        rd(8'h08, r);
        chk(32'(r[9]), 32'h0000_0000);
        $display("test glyph and shift done");
        wr(8'h00, 8'h90);
        wr(8'h00, 8'h03);
        chk(32'({ptr, shift}), 32'h0000_0000);
        rdchk(8'h04, 32'h0000_005a);
        wr(8'h00, 8'h04);
        wr(8'h00, 8'h01);
        chk(32'({ptr, shift}), 32'h0000_0000);
        rd(8'h08, r);
        chk(32'(r[0]), 32'h0000_0001);
        rdchk(8'h04, 32'h0000_0020);
        wr(8'h00, 8'h7f);
        rdchk(8'h04, 32'h0000_00a5);
        $display("test home and clear done");
        stop_test();
    end
endmodule // tb_cdi_instruction_unit
bind cdi_instruction_unit cdi_instruction_unit_sva #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_sva (.mclk_in, .rst_n_in,
    .hsel_in, .htrans_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .display_on_out, .cursor_on_out,
    .blink_show_full_out, .bus_width_bit_out, .two_lines_out, .luminance_out, .shift_offset_out, .cursor_addr_out);
`default_nettype wire
